// ### hdl/abg_burst_seq.sv
`timescale 1ns/1ps
`include "abg_map.svh"
module abg_burst_seq (
  input wire logic clk,
  input wire logic rstn,
  input wire logic burst_enable_bit,
  input wire logic converter_enable_bit,
  input wire abg_pkg::abg_rep_sel_t rep_sel,
  input wire logic [3:0] powerup_time_field,
  input wire logic start,
  input wire logic osc_tick,
  input wire logic conv_done,
  output logic conv_launch,
  output logic adc_power,
  output logic sample_take,
  output logic sample_first,
  output logic seq_done,
  output abg_pkg::abg_state_t seq_state
);
  import abg_pkg::*;

  abg_state_t state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic [6:0] wait_q, wait_d;
  logic [4:0] rep_total;
  logic last;
  logic [6:0] pwr_cycles;

  // ============================================================
  // decode
  assign rep_total = (rep_sel == 2'h0) ? 5'h01 :
                     (rep_sel == 2'h1) ? 5'h04 :
                     (rep_sel == 2'h2) ? 5'h08 : 5'h10;
  assign last = ((cnt_q + 5'h01) == rep_total);
  assign pwr_cycles = 7'(({3'h0, powerup_time_field} + 7'h01) *
                         7'(`ABG_PWRUP_UNIT_CYC)) - 7'h01;
  assign conv_launch = (state_q == ST_IDLE && start && !burst_enable_bit &&
                        converter_enable_bit) ||
                       (state_q == ST_TRACK && osc_tick);
  assign adc_power = converter_enable_bit ||
                     (burst_enable_bit && state_q != ST_IDLE);
  assign sample_take = (state_q == ST_CONV) && conv_done;
  assign sample_first = (cnt_q == 5'h00);
  assign seq_done = sample_take && last;
  assign seq_state = state_q;

  // ============================================================
  // sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    wait_d = wait_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start && burst_enable_bit) begin
          if (converter_enable_bit) begin
            state_d = ST_TRACK;
          end else begin
            state_d = ST_PWRUP;
            wait_d = pwr_cycles;
          end
        end else if (start && converter_enable_bit) begin
          state_d = ST_CONV;
        end
      end
      ST_PWRUP: begin
        if (wait_q == 7'h00) begin
          state_d = ST_TRACK;
        end else begin
          wait_d = wait_q - 7'h01;
        end
      end
      ST_TRACK: begin
        if (osc_tick) begin
          state_d = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_done) begin
          if (last) begin
            cnt_d = 5'h00;
            state_d = ST_IDLE;
          end else begin
            cnt_d = cnt_q + 5'h01;
            state_d = burst_enable_bit ? ST_TRACK : ST_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      cnt_q <= 5'h00;
      wait_q <= 7'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      wait_q <= wait_d;
    end
  end

  // ============================================================
  // checks
  a_pwrup_from_off: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == ST_IDLE && start && burst_enable_bit && !converter_enable_bit)
    |=> state_q == ST_PWRUP ##1 (state_q == ST_PWRUP)[*4])
    else $error("sleeping converter did not wait for power-up");
  a_powered_direct: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == ST_IDLE && start && burst_enable_bit && converter_enable_bit)
    |=> state_q == ST_TRACK)
    else $error("powered converter did not track at once");
  a_single_conv: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == ST_IDLE && start && !burst_enable_bit && converter_enable_bit)
    |-> conv_launch ##1 state_q == ST_CONV)
    else $error("non-burst start did not launch one conversion");
  a_osc_paced: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == ST_TRACK && !osc_tick) |=> state_q == ST_TRACK && !$past(conv_launch))
    else $error("burst conversion launched without oscillator tick");
  a_burst_sleep: assert property (@(posedge clk) disable iff (!rstn)
    (seq_done && burst_enable_bit && !converter_enable_bit) |=> !adc_power)
    else $error("converter stayed powered after burst");
  a_reset_idle: assert property (@(posedge clk)
    !rstn |=> state_q == ST_IDLE && cnt_q == 5'h00)
    else $error("reset left sequencer busy");
  c_burst_from_off: cover property (@(posedge clk) disable iff (!rstn)
    state_q == ST_PWRUP ##[1:100] seq_done);
  c_burst_sixteen: cover property (@(posedge clk) disable iff (!rstn)
    seq_done && rep_sel == 2'h3 && burst_enable_bit);
endmodule // abg_burst_seq

// ### hdl/abg_map.svh
`ifndef ABG_MAP_SVH
`define ABG_MAP_SVH
// Operation
// - In burst operation the converter wakes, accumulates 1, 4, 8 or 16 samples on burst oscillator ticks, then idles again.
// - Burst operation runs only while burst enable is set, and converter enable then picks the idle power state.
// - A start in burst operation powers up a sleeping converter for the programmed time, or starts tracking at once if it is powered.
// - One start launches repeat-count conversions in burst operation, and exactly one conversion otherwise.
// - The conversion-done flag sets only after the whole repeat count has been accumulated.
// - The window compare looks at the result only after the whole repeat count has been accumulated.
// - Burst conversions are paced by the burst oscillator, not by the system clock.
// - The gain high register holds the upper eight bits of the gain word.
// - A set extra gain bit adds one sixty-fourth to the gain given by the gain word.

// ============================================================
// register indices (byte address = 4 * index)
`define ABG_IDX_CTRL 6'h00
`define ABG_IDX_STAT 6'h01
`define ABG_IDX_RESULT 6'h02
`define ABG_IDX_WIN_HI 6'h03
`define ABG_IDX_GAIN_HIGH 6'h04
`define ABG_IDX_WIN_LO 6'h05
`define ABG_IDX_GAIN_LOW 6'h07
`define ABG_IDX_GAIN_EXTRA 6'h08

// ============================================================
// field positions
`define ABG_CTRL_BURST 0
`define ABG_CTRL_CONV_EN 1
`define ABG_CTRL_REP_LSB 2
`define ABG_CTRL_PWR_LSB 4
`define ABG_CTRL_START 8
`define ABG_STAT_DONE 0
`define ABG_STAT_WIN 1
`define ABG_STAT_BUSY 2
`define ABG_STAT_POWER 3

// ============================================================
// reset values
`define ABG_RST_CTRL 9'h000
`define ABG_RST_GAIN_HIGH 8'h00
`define ABG_RST_GAIN_LOW 8'h00
`define ABG_RST_GAIN_EXTRA 8'h01
`define ABG_RST_WIN_HI 16'hFFFF
`define ABG_RST_WIN_LO 16'h0000

// ============================================================
// timing and gain constants
`define ABG_CLK_NS 40
`define ABG_PWRUP_UNIT_NS 200
`define ABG_PWRUP_UNIT_CYC ((`ABG_PWRUP_UNIT_NS + `ABG_CLK_NS - 1) / `ABG_CLK_NS)
`define ABG_EXTRA_GAIN_LSB 13'h0040
`endif

// ### hdl/abg_pkg.sv
package abg_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PWRUP,
    ST_TRACK,
    ST_CONV
  } abg_state_t;
  typedef logic [1:0] abg_rep_sel_t;
endpackage

// ### hdl/abg_top.sv
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "abg_map.svh"
module abg_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_start,
  input wire logic burst_osc,
  input wire logic conv_done,
  input wire logic [11:0] conv_data,
  output logic conv_launch,
  output logic adc_power,
  output logic conversion_done_flag,
  output logic window_flag,
  output logic [11:0] gain_word,
  output logic extra_gain_bit,
  output logic [12:0] gain_total
);
  import abg_pkg::*;

  logic ack_q;
  logic [31:0] prdata_q;
  logic [8:0] ctrl_q;
  logic [7:0] gain_high_q, gain_low_q, gain_extra_q;
  logic [15:0] win_hi_q, win_lo_q, acc_q, result_q;
  logic done_q, win_q;
  logic [1:0] ext_sync_q, osc_sync_q;
  logic ext_prev_q, osc_prev_q;
  abg_state_t seq_state;
  logic sample_take, sample_first, seq_done;

  // ============================================================
  // apb decode
  logic access, wr_fire, mapped;
  logic [5:0] idx;
  logic sel_ctrl, sel_stat, sel_res, sel_whi, sel_wlo;
  logic sel_gh, sel_gl, sel_gx;
  logic [31:0] rd_mux;

  assign idx = paddr[7:2];
  assign access = psel && penable;
  // one wait state so read data comes from a flop
  assign pready = access && ack_q;
  assign wr_fire = pready && pwrite && mapped;
  assign sel_ctrl = (idx == `ABG_IDX_CTRL);
  assign sel_stat = (idx == `ABG_IDX_STAT);
  assign sel_res = (idx == `ABG_IDX_RESULT);
  assign sel_whi = (idx == `ABG_IDX_WIN_HI);
  assign sel_wlo = (idx == `ABG_IDX_WIN_LO);
  assign sel_gh = (idx == `ABG_IDX_GAIN_HIGH);
  assign sel_gl = (idx == `ABG_IDX_GAIN_LOW);
  assign sel_gx = (idx == `ABG_IDX_GAIN_EXTRA);
  assign mapped = (paddr[1:0] == 2'h0) && (sel_ctrl || sel_stat || sel_res ||
                  sel_whi || sel_wlo || sel_gh || sel_gl || sel_gx);
  assign pslverr = pready && !mapped;
  assign prdata = prdata_q;

  logic [31:0] stat_word;
  assign stat_word = {28'h0000000, adc_power, (seq_state != ST_IDLE),
                      win_q, done_q};
  assign rd_mux = sel_ctrl ? {24'h000000, ctrl_q[7:0]} :
                  sel_stat ? stat_word :
                  sel_res ? {16'h0000, result_q} :
                  sel_whi ? {16'h0000, win_hi_q} :
                  sel_wlo ? {16'h0000, win_lo_q} :
                  sel_gh ? {24'h000000, gain_high_q} :
                  sel_gl ? {24'h000000, gain_low_q} :
                  sel_gx ? {24'h000000, gain_extra_q} : 32'h00000000;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ack_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      ack_q <= access && !ack_q;
      if (access && !ack_q) begin
        prdata_q <= (mapped && !pwrite) ? rd_mux : 32'h00000000;
      end
    end
  end

  // ============================================================
  // pin synchronisers and edge detect
  logic ext_rise, osc_tick, sw_start, start;
  assign ext_rise = ext_sync_q[1] && !ext_prev_q;
  assign osc_tick = osc_sync_q[1] && !osc_prev_q;
  assign sw_start = wr_fire && sel_ctrl && pwdata[`ABG_CTRL_START];
  assign start = sw_start || ext_rise;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ext_sync_q <= 2'h0;
      osc_sync_q <= 2'h0;
      ext_prev_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      ext_sync_q <= {ext_sync_q[0], ext_start};
      osc_sync_q <= {osc_sync_q[0], burst_osc};
      ext_prev_q <= ext_sync_q[1];
      osc_prev_q <= osc_sync_q[1];
    end
  end

  // ============================================================
  // control and gain registers
  // gain reset values
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_q <= `ABG_RST_CTRL;
      gain_high_q <= `ABG_RST_GAIN_HIGH;
      gain_low_q <= `ABG_RST_GAIN_LOW;
      gain_extra_q <= `ABG_RST_GAIN_EXTRA;
      win_hi_q <= `ABG_RST_WIN_HI;
      win_lo_q <= `ABG_RST_WIN_LO;
    end else if (wr_fire) begin
      if (sel_ctrl) begin
        ctrl_q <= {1'b0, pwdata[7:0]};
      end
      if (sel_gh) begin
        gain_high_q <= pwdata[7:0];
      end
      if (sel_gl) begin
        gain_low_q <= pwdata[7:0];
      end
      if (sel_gx) begin
        gain_extra_q <= pwdata[7:0];
      end
      if (sel_whi) begin
        win_hi_q <= pwdata[15:0];
      end
      if (sel_wlo) begin
        win_lo_q <= pwdata[15:0];
      end
    end
  end

  // ============================================================
  // gain word
  // upper eight bits
  assign gain_word = {gain_high_q, gain_low_q[7:4]};
  assign extra_gain_bit = gain_extra_q[0];
  assign gain_total = {1'b0, gain_word} +
                      (extra_gain_bit ? `ABG_EXTRA_GAIN_LSB : 13'h0000);

  // ============================================================
  // sequencer
  abg_burst_seq u_seq (
    .clk(clk),
    .rstn(rstn),
    .burst_enable_bit(ctrl_q[`ABG_CTRL_BURST]),
    .converter_enable_bit(ctrl_q[`ABG_CTRL_CONV_EN]),
    .rep_sel(ctrl_q[`ABG_CTRL_REP_LSB +: 2]),
    .powerup_time_field(ctrl_q[`ABG_CTRL_PWR_LSB +: 4]),
    .start(start),
    .osc_tick(osc_tick),
    .conv_done(conv_done),
    .conv_launch(conv_launch),
    .adc_power(adc_power),
    .sample_take(sample_take),
    .sample_first(sample_first),
    .seq_done(seq_done),
    .seq_state(seq_state)
  );

  // ============================================================
  // accumulator, result and window compare
  logic [15:0] acc_sum;
  logic win_hit, clr_done, clr_win;
  assign acc_sum = (sample_first ? 16'h0000 : acc_q) + {4'h0, conv_data};
  assign win_hit = (acc_sum > win_hi_q) || (acc_sum < win_lo_q);
  assign clr_done = wr_fire && sel_stat && pwdata[`ABG_STAT_DONE];
  assign clr_win = wr_fire && sel_stat && pwdata[`ABG_STAT_WIN];
  assign conversion_done_flag = done_q;
  assign window_flag = win_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      acc_q <= 16'h0000;
      result_q <= 16'h0000;
      done_q <= 1'b0;
      win_q <= 1'b0;
    end else begin
      if (sample_take) begin
        acc_q <= acc_sum;
      end
      if (seq_done) begin
        result_q <= acc_sum;
      end
      done_q <= seq_done || (done_q && !clr_done);
      win_q <= (seq_done && win_hit) || (win_q && !clr_win);
    end
  end

  // ============================================================
  // checks
  a_done_on_count: assert property (@(posedge clk) disable iff (!rstn)
    $rose(done_q) |-> $past(seq_done) && $past(seq_state) == ST_CONV)
    else $error("done flag set before repeat count finished");
  a_window_gate: assert property (@(posedge clk) disable iff (!rstn)
    $rose(win_q) |-> $past(seq_done))
    else $error("window flag set before repeat count finished");
  a_gain_high: assert property (@(posedge clk) disable iff (!rstn)
    (wr_fire && sel_gh) |=> gain_word[11:4] == $past(pwdata[7:0]))
    else $error("gain high byte not placed in gain word");
  a_gain_low: assert property (@(posedge clk) disable iff (!rstn)
    (wr_fire && sel_gl) |=> gain_word[3:0] == $past(pwdata[7:4]))
    else $error("gain low nibble not placed in gain word");
  a_extra_gain: assert property (@(posedge clk) disable iff (!rstn)
    (wr_fire && sel_gx && pwdata[0]) |=> gain_total == {1'b0, gain_word} + 13'h0040)
    else $error("extra gain did not add one sixty-fourth");
  a_gain_reset: assert property (@(posedge clk)
    !rstn |=> gain_extra_q == 8'h01 && gain_low_q == 8'h00 && !done_q)
    else $error("reset did not restore gain registers");
  a_done_sticky: assert property (@(posedge clk) disable iff (!rstn)
    (done_q && !clr_done) |=> done_q)
    else $error("done flag dropped without a clear");
  a_done_cleared: assert property (@(posedge clk) disable iff (!rstn)
    (done_q && clr_done && !seq_done) |=> !done_q)
    else $error("done flag ignored its clear");
  a_result_load: assert property (@(posedge clk) disable iff (!rstn)
    seq_done |=> result_q == $past(acc_sum))
    else $error("result not loaded with the finished sum");
  a_window_clear: assert property (@(posedge clk) disable iff (!rstn)
    (win_q && clr_win && !seq_done) |=> !win_q)
    else $error("window flag ignored its clear");
  // a refused write must leave the control and gain registers alone
  a_refused_write: assert property (@(posedge clk) disable iff (!rstn)
    (pready && pwrite && !mapped) |=> $stable(gain_high_q) &&
    $stable(gain_low_q) && $stable(gain_extra_q) && $stable(ctrl_q))
    else $error("refused write changed a register");
  a_ready_wait: assert property (@(posedge clk) disable iff (!rstn)
    $rose(access) |-> !pready)
    else $error("bus answered without its wait state");
  c_done_seen: cover property (@(posedge clk) disable iff (!rstn)
    seq_done ##1 done_q);
  c_window_hit: cover property (@(posedge clk) disable iff (!rstn)
    $rose(win_q));
  c_clear_race: cover property (@(posedge clk) disable iff (!rstn)
    seq_done && clr_done);
endmodule // abg_top

// ### tb/abg_top_test.sv
`timescale 1ns/1ps
`include "abg_map.svh"
module abg_top_test;
  import abg_pkg::*;
  logic clk, rstn, psel, penable, pwrite, ext_start;
  logic burst_osc = 1'b0;
  logic conv_done = 1'b0;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, conv_launch, adc_power, conversion_done_flag;
  logic window_flag, extra_gain_bit, osc_run;
  logic d1 = 1'b0;
  logic [11:0] conv_data = 12'h000;
  logic [11:0] gain_word;
  logic [12:0] gain_total;
  logic [1:0] div = 2'h0;
  int num_errors, n_compared, t_start, first_l, base_l, base_r;
  int cyc = 0;
  int n_launch = 0;
  int n_ret = 0;
  logic [15:0] sum = 16'h0000;
  logic [15:0] base_sum;

  abg_top u_abg_top (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_start(ext_start),
    .burst_osc(burst_osc), .conv_done(conv_done), .conv_data(conv_data),
    .conv_launch(conv_launch), .adc_power(adc_power),
    .conversion_done_flag(conversion_done_flag), .window_flag(window_flag),
    .gain_word(gain_word), .extra_gain_bit(extra_gain_bit),
    .gain_total(gain_total));

  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  // ============================================================
  // converter stand-in: answers each launch two cycles later
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (conv_launch === 1'b1) begin
      n_launch = n_launch + 1;
      if (n_launch == base_l + 1) first_l = cyc;
    end
    d1 <= conv_launch;
    conv_done <= d1;
    if (d1 === 1'b1) begin
      conv_data <= 12'h100 + 12'(n_ret);
      sum = sum + 16'h0100 + 16'(n_ret);
      n_ret = n_ret + 1;
    end
    // oscillator stands still between bursts
    if (osc_run) begin
      div <= div + 2'h1;
      if (div == 2'h3) burst_osc <= ~burst_osc;
    end
  end

  // ============================================================
  // shared tasks
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic apb(input int wr, input logic [5:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= 1'(wr);
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // ready, read data and response all taken at one rising edge
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      num_errors++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    t_start = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
    // outputs updated by the write only settle after this edge
    @(negedge clk);
  endtask

  // ============================================================
  // scenarios
  task automatic reset_and_gain;
    logic [31:0] rd;
    logic e;
    apb(0, `ABG_IDX_GAIN_HIGH, 0, rd, e);
    check("gain_high_rst", rd, 32'h00);
    apb(0, `ABG_IDX_GAIN_LOW, 0, rd, e);
    check("gain_low_rst", rd, 32'h00);
    apb(0, `ABG_IDX_GAIN_EXTRA, 0, rd, e);
    check("gain_extra_rst", rd, 32'h01);
    check("gain_total_rst", gain_total, 32'h040);
    apb(0, 6'h06, 0, rd, e);
    check("unmapped_err", e, 1);
    check("unmapped_data", rd, 0);
    apb(1, 6'h06, 32'hFF, rd, e);
    check("unmapped_wr_err", e, 1);
    // reserved bits always written as zero
    // reserved zero
    apb(1, `ABG_IDX_GAIN_HIGH, 32'hAB, rd, e);
    apb(1, `ABG_IDX_GAIN_LOW, 32'hC0, rd, e);
    apb(1, `ABG_IDX_GAIN_EXTRA, 32'h00, rd, e);
    check("gain_word", gain_word, 32'hABC);
    check("gain_plain", gain_total, 32'hABC);
    check("extra_off", extra_gain_bit, 0);
    apb(0, `ABG_IDX_GAIN_LOW, 0, rd, e);
    check("gain_low_rb", rd, 32'hC0);
    apb(1, `ABG_IDX_GAIN_EXTRA, 32'h01, rd, e);
    check("gain_extra", gain_total, 32'hAFC);
  endtask

  task automatic nonburst_run;
    logic [31:0] rd;
    logic e;
    int k;
    // start with converter disabled is refused
    apb(1, `ABG_IDX_CTRL, 32'h100, rd, e);
    repeat (6) @(negedge clk);
    check("nb_refused", n_launch, 0);
    apb(1, `ABG_IDX_CTRL, 32'h006, rd, e);
    for (k = 0; k < 4; k++) begin
      apb(1, `ABG_IDX_CTRL, 32'h106, rd, e);
      repeat (6) @(negedge clk);
      check("nb_launch", n_launch, k + 1);
      check("nb_done", conversion_done_flag, k == 3);
    end
    apb(1, `ABG_IDX_STAT, 32'h3, rd, e);
  endtask

  task automatic burst_run(input logic [1:0] rep, input logic en,
                           input logic ext, input logic win);
    logic [31:0] rd, cfg;
    logic e;
    int i, n;
    n = 1 << (rep == 2'h0 ? 0 : rep + 1);
    cfg = {28'h0, rep, en, 1'b1};
    apb(1, `ABG_IDX_WIN_LO, win ? 32'h2000 : 32'h0, rd, e);
    // tracking mode is a software concern
    apb(1, `ABG_IDX_CTRL, cfg, rd, e);
    @(negedge clk);
    base_l = n_launch;
    base_r = n_ret;
    base_sum = sum;
    osc_run = 1;
    check("power_idle", adc_power, en);
    if (ext) begin
      @(posedge clk);
      ext_start <= 1'b1;
      repeat (4) @(posedge clk);
      ext_start <= 1'b0;
    end else begin
      apb(1, `ABG_IDX_CTRL, cfg | 32'h100, rd, e);
    end
    for (i = 0; i < 3000; i++) begin
      @(negedge clk);
      if (conversion_done_flag === 1'b1) break;
      if (window_flag !== 1'b0) check("win_early", window_flag, 0);
      if (conv_launch === 1'b1 && adc_power !== 1'b1)
        check("launch_power", adc_power, 1);
    end
    if (i == 3000) begin
      num_errors++;
      tally_and_finish();
    end
    check("launches", n_launch - base_l, n);
    check("returned", n_ret - base_r, n);
    // five power-up cycles lie between the start edge and the first launch
    if (!en && !ext) check("pwrup_wait", first_l - t_start >= 6, 1);
    repeat (2) @(negedge clk);
    check("window", window_flag, win);
    osc_run = 0;
    apb(0, `ABG_IDX_RESULT, 0, rd, e);
    check("result", rd, 16'(sum - base_sum));
    repeat (4) @(negedge clk);
    check("power_after", adc_power, en);
    apb(1, `ABG_IDX_STAT, 32'h3, rd, e);
    @(negedge clk);
    check("done_clear", conversion_done_flag, 0);
  endtask

  // ============================================================
  // main sequence
  initial begin
    rstn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_start = 0;
    osc_run = 0;
    num_errors = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check("done_rst", conversion_done_flag, 0);
    check("power_rst", adc_power, 0);
    reset_and_gain();
    nonburst_run();
    burst_run(2'h0, 1'b1, 1'b0, 1'b0);
    burst_run(2'h1, 1'b1, 1'b0, 1'b1);
    burst_run(2'h2, 1'b0, 1'b1, 1'b0);
    burst_run(2'h3, 1'b0, 1'b0, 1'b0);
    tally_and_finish();
  end
endmodule // abg_top_test
